// ---- rtl/irq_pkg.sv ----
// register map, field positions and reset values of the interrupt source logic
// assumes a byte-wide register port and one 100 MHz clock
// Operation
// - external pin fires on rising edge when polarity bit is 1, else on falling edge
// - a valid edge sets that pin's flag; the flag stays set until cleared
// - a clear enable bit blocks the request while the flag still records edges
// - any external source wakes the core if enabled before power-managed entry
// - after wake the core vectors only when the global enable is set
// - priority of external sources one and two sits at third control bits 6, 7
// - external source zero has no priority bit and is always high priority
// - in 8-bit mode the timer flag sets when the low byte wraps to zero
// - in 16-bit mode the timer flag sets when the full pair wraps to zero
// - timer interrupt is gated by main control bit 5
// - timer priority comes from second control bit 2
// - any change on port pins 7 to 4 sets main control bit 0
// - pin-change enable is main bit 3, its priority second control bit 0
// - entry pushes return address and shadows working, status and bank registers
// - reset-cause bit 7 enables two priority levels; resets to 0
// - reset-cause bits 6, 5 read zero; flags sit at bits 4 down to 0
// - timeout and power-down are read-only, reset to 1; instruction flag writable, 1
// - priorities act only with level enable; else peripherals need peripheral enable
package irq_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int PC_W   = 21;
  localparam int STACK_DEPTH = 31;

  localparam logic [ADDR_W-1:0] OFS_CTRL_MAIN   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL_SECOND = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CTRL_THIRD  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_TIMER_LOW   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_TIMER_HIGH  = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_TIMER_CFG   = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_STACK_STAT  = 4'h7;

  localparam int MAIN_GLOBAL  = 7;
  localparam int MAIN_PERIPH  = 6;
  localparam int MAIN_T0_EN   = 5;
  localparam int MAIN_X0_EN   = 4;
  localparam int MAIN_PC_EN   = 3;
  localparam int MAIN_T0_FLAG = 2;
  localparam int MAIN_X0_FLAG = 1;
  localparam int MAIN_PC_FLAG = 0;

  localparam int SEC_EDGE0   = 6;
  localparam int SEC_EDGE1   = 5;
  localparam int SEC_EDGE2   = 4;
  localparam int SEC_T0_PRIO = 2;
  localparam int SEC_PC_PRIO = 0;

  localparam int THR_X2_PRIO = 7;
  localparam int THR_X1_PRIO = 6;
  localparam int THR_X2_EN   = 4;
  localparam int THR_X1_EN   = 3;
  localparam int THR_X2_FLAG = 1;
  localparam int THR_X1_FLAG = 0;

  localparam int RC_PRIO_EN = 7;
  localparam int RC_RI      = 4;
  localparam int RC_TO      = 3;
  localparam int RC_PD      = 2;
  localparam int RC_POR     = 1;
  localparam int RC_BOR     = 0;

  localparam int CFG_RUN   = 7;
  localparam int CFG_EIGHT = 6;

  localparam logic [DATA_W-1:0] MAIN_RST   = 8'h00;
  localparam logic [DATA_W-1:0] SECOND_RST = 8'h75;
  localparam logic [DATA_W-1:0] THIRD_RST  = 8'hC0;
  localparam logic [DATA_W-1:0] RC_RST     = 8'h1C;
  localparam logic [DATA_W-1:0] CFG_RST    = 8'h40;

  localparam logic [DATA_W-1:0] SECOND_WMASK = 8'h75;
  localparam logic [DATA_W-1:0] THIRD_WMASK  = 8'hDB;
  localparam logic [DATA_W-1:0] RC_WMASK     = 8'h93;
  localparam logic [DATA_W-1:0] CFG_WMASK    = 8'hC0;
  localparam logic [DATA_W-1:0] BYTE_ONES    = 8'hFF;
  localparam logic [15:0]       WORD_ONES    = 16'hFFFF;
endpackage

// ---- rtl/ctx_return_stack.sv ----
// return address stack memory with registered read data
// assumes the owner keeps the pointer and never reads and writes one entry at once
`timescale 1ns/10ps
module ctx_return_stack #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 31,
  parameter int AW    = 5
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rdata;
  } stack_state_t;

  stack_state_t st_reg;
  stack_state_t st_next;

  if (DEPTH < 2 || (1 << AW) <= DEPTH) begin : g_bad_depth
    $error("stack depth does not fit the address width");
  end

  always_comb begin
    st_next = st_reg;
    if (wr_en && int'(wr_addr) < DEPTH) begin
      st_next.mem[wr_addr] = wr_data;
    end
    if (rd_en && int'(rd_addr) < DEPTH) begin
      st_next.rdata = st_reg.mem[rd_addr];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rdata;
endmodule

// ---- rtl/ext_timer_pinchange_irq_logic.sv ----
// interrupt sources: three edge pins, timer zero, port pin-change, reset cause, context
// assumes pins are asynchronous; core strobes and register port share ref_clk
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module ext_timer_pinchange_irq_logic
  import irq_pkg::*;
#(
  parameter int STACK_D = STACK_DEPTH
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic [2:0]        ext_pin,
  input  wire logic [3:0]        port_b_a_hi,
  input  wire logic              periph_req,
  input  wire logic              periph_high,
  input  wire logic              power_managed,
  input  wire logic              irq_enter,
  input  wire logic              irq_enter_high,
  input  wire logic              irq_return,
  input  wire logic              irq_return_fast,
  input  wire logic [PC_W-1:0]   pc_in,
  input  wire logic [7:0]        working_register_in,
  input  wire logic [7:0]        status_in,
  input  wire logic [7:0]        bank_select_in,
  input  wire logic              reset_instr_event,
  input  wire logic              wdt_timeout_event,
  input  wire logic              wdt_clear_event,
  input  wire logic              brownout_event,
  output logic                   irq_high_req,
  output logic                   irq_low_req,
  output logic                   wake_req,
  output logic                   wake_vector,
  output logic      [PC_W-1:0]   return_pc,
  output logic                   return_pc_valid,
  output logic      [7:0]        working_register_out,
  output logic      [7:0]        status_out,
  output logic      [7:0]        bank_select_out,
  output logic                   restore_valid
);
  localparam int SP_W = $clog2(STACK_D + 1);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_D);
  localparam logic [SP_W-1:0] SP_ONE  = SP_W'(1);

  if (STACK_D < 2 || SP_W > DATA_W) begin : g_bad_stack
    $error("stack depth out of range");
  end

  typedef struct packed {
    logic [2:0]        ext_meta;
    logic [2:0]        ext_sync;
    logic [2:0]        ext_prev;
    logic [3:0]        pb_meta;
    logic [3:0]        pb_sync;
    logic [3:0]        pb_prev;
    logic [DATA_W-1:0] ctrl_main;
    logic [DATA_W-1:0] ctrl_second;
    logic [DATA_W-1:0] ctrl_third;
    logic [DATA_W-1:0] reset_cause;
    logic [DATA_W-1:0] timer_cfg;
    logic [15:0]       timer;
    logic [2:0]        wake_en;
    logic              pm_prev;
    logic [SP_W-1:0]   sp;
    logic [DATA_W-1:0] rdata;
    logic [7:0]        shadow_w;
    logic [7:0]        shadow_s;
    logic [7:0]        shadow_b;
    logic              ret_valid;
    logic              fast_valid;
  } irq_state_t;

  irq_state_t st_reg;
  irq_state_t st_next;

  logic [2:0]      ext_edge;
  logic [2:0]      ext_pol;
  logic [2:0]      ext_en;
  logic            pb_change;
  logic            t0_ovf;
  logic            priority_levels_enable;
  logic            act_x0;
  logic            act_x1;
  logic            act_x2;
  logic            act_t0;
  logic            act_pc;
  logic            high_set;
  logic            low_set;
  logic            any_set;
  logic            push;
  logic            pop;
  logic [SP_W-1:0] pop_addr;
  logic [PC_W-1:0] stack_rd;

  assign ext_pol = {st_reg.ctrl_second[SEC_EDGE2], st_reg.ctrl_second[SEC_EDGE1],
                    st_reg.ctrl_second[SEC_EDGE0]};
  assign ext_en  = {st_reg.ctrl_third[THR_X2_EN], st_reg.ctrl_third[THR_X1_EN],
                    st_reg.ctrl_main[MAIN_X0_EN]};

  for (genvar i = 0; i < 3; i++) begin : g_edge
    // rising when polarity is one, falling otherwise
    assign ext_edge[i] = ext_pol[i] ? (st_reg.ext_sync[i] & ~st_reg.ext_prev[i])
                                    : (~st_reg.ext_sync[i] & st_reg.ext_prev[i]);
  end

  assign pb_change = |(st_reg.pb_sync ^ st_reg.pb_prev);
  assign t0_ovf = st_reg.timer_cfg[CFG_RUN] &&
                  (st_reg.timer_cfg[CFG_EIGHT] ? (st_reg.timer[7:0] == BYTE_ONES)
                                               : (st_reg.timer == WORD_ONES));

  assign priority_levels_enable   = st_reg.reset_cause[RC_PRIO_EN];
  assign act_x0 = st_reg.ctrl_main[MAIN_X0_FLAG] & st_reg.ctrl_main[MAIN_X0_EN];
  assign act_x1 = st_reg.ctrl_third[THR_X1_FLAG] & st_reg.ctrl_third[THR_X1_EN];
  assign act_x2 = st_reg.ctrl_third[THR_X2_FLAG] & st_reg.ctrl_third[THR_X2_EN];
  assign act_t0 = st_reg.ctrl_main[MAIN_T0_FLAG] & st_reg.ctrl_main[MAIN_T0_EN];
  assign act_pc = st_reg.ctrl_main[MAIN_PC_FLAG] & st_reg.ctrl_main[MAIN_PC_EN];

  // source zero joins the high set unconditionally
  assign high_set = act_x0
                  | (act_x1 & st_reg.ctrl_third[THR_X1_PRIO])
                  | (act_x2 & st_reg.ctrl_third[THR_X2_PRIO])
                  | (act_t0 & st_reg.ctrl_second[SEC_T0_PRIO])
                  | (act_pc & st_reg.ctrl_second[SEC_PC_PRIO])
                  | (periph_req & periph_high);
  assign low_set  = (act_x1 & ~st_reg.ctrl_third[THR_X1_PRIO])
                  | (act_x2 & ~st_reg.ctrl_third[THR_X2_PRIO])
                  | (act_t0 & ~st_reg.ctrl_second[SEC_T0_PRIO])
                  | (act_pc & ~st_reg.ctrl_second[SEC_PC_PRIO])
                  | (periph_req & ~periph_high);
  // single level: peripheral sources also need the peripheral enable
  assign any_set  = act_x0 | act_x1 | act_x2 | act_t0 | act_pc
                  | (periph_req & st_reg.ctrl_main[MAIN_PERIPH]);

  always_comb begin
    irq_high_req = 1'b0;
    irq_low_req  = 1'b0;
    if (priority_levels_enable) begin
      irq_high_req = high_set & st_reg.ctrl_main[MAIN_GLOBAL];
      irq_low_req  = low_set & st_reg.ctrl_main[MAIN_GLOBAL] & st_reg.ctrl_main[MAIN_PERIPH];
    end else begin
      irq_high_req = any_set & st_reg.ctrl_main[MAIN_GLOBAL];
    end
  end

  // wake uses the enables captured when the power-managed mode was entered
  assign wake_req = power_managed &&
                    |(st_reg.wake_en & {st_reg.ctrl_third[THR_X2_FLAG],
                                        st_reg.ctrl_third[THR_X1_FLAG],
                                        st_reg.ctrl_main[MAIN_X0_FLAG]});
  assign wake_vector = wake_req & st_reg.ctrl_main[MAIN_GLOBAL];

  assign push     = irq_enter && st_reg.sp != SP_FULL;
  assign pop      = irq_return && st_reg.sp != '0;
  assign pop_addr = st_reg.sp - SP_ONE;

  ctx_return_stack #(
    .WIDTH (PC_W),
    .DEPTH (STACK_D),
    .AW    (SP_W)
  ) u_stack (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (push),
    .wr_addr (st_reg.sp),
    .wr_data (pc_in),
    .rd_en   (pop),
    .rd_addr (pop_addr),
    .rd_data (stack_rd)
  );

  always_comb begin
    st_next = st_reg;
    st_next.ext_meta = ext_pin;
    st_next.ext_sync = st_reg.ext_meta;
    st_next.ext_prev = st_reg.ext_sync;
    st_next.pb_meta  = port_b_a_hi;
    st_next.pb_sync  = st_reg.pb_meta;
    st_next.pb_prev  = st_reg.pb_sync;
    st_next.pm_prev  = power_managed;
    st_next.ret_valid  = pop;
    st_next.fast_valid = pop & irq_return_fast;

    // timer counts; a register write in the same cycle takes precedence
    if (st_reg.timer_cfg[CFG_RUN]) begin
      if (st_reg.timer_cfg[CFG_EIGHT]) begin
        st_next.timer[7:0] = st_reg.timer[7:0] + 8'h01;
      end else begin
        st_next.timer = st_reg.timer + 16'h0001;
      end
    end

    if (wr_en) begin
      case (addr)
        OFS_CTRL_MAIN:   st_next.ctrl_main = wdata;
        OFS_CTRL_SECOND: st_next.ctrl_second = wdata & SECOND_WMASK;
        OFS_CTRL_THIRD:  st_next.ctrl_third = wdata & THIRD_WMASK;
        OFS_RESET_CAUSE: begin
          st_next.reset_cause = (st_reg.reset_cause & ~RC_WMASK) | (wdata & RC_WMASK);
        end
        OFS_TIMER_LOW:   st_next.timer[7:0] = wdata;
        OFS_TIMER_HIGH:  st_next.timer[15:8] = wdata;
        OFS_TIMER_CFG:   st_next.timer_cfg = wdata & CFG_WMASK;
        default: ;
      endcase
    end

    // capture wake enables on entry to the power-managed mode
    if (power_managed && !st_reg.pm_prev) begin
      st_next.wake_en = ext_en;
      st_next.reset_cause[RC_PD] = 1'b0;
    end

    // hardware events on reset-cause flags
    if (wdt_clear_event) begin
      st_next.reset_cause[RC_TO] = 1'b1;
      st_next.reset_cause[RC_PD] = 1'b1;
    end
    if (wdt_timeout_event) begin
      st_next.reset_cause[RC_TO] = 1'b0;
    end
    if (reset_instr_event) begin
      st_next.reset_cause[RC_RI] = 1'b0;
    end
    if (brownout_event) begin
      st_next.reset_cause[RC_BOR] = 1'b0;
    end

    // entry drops the enable of the level taken, return restores it
    if (irq_enter) begin
      st_next.shadow_w = working_register_in;
      st_next.shadow_s = status_in;
      st_next.shadow_b = bank_select_in;
      if (priority_levels_enable && !irq_enter_high) begin
        st_next.ctrl_main[MAIN_PERIPH] = 1'b0;
      end else begin
        st_next.ctrl_main[MAIN_GLOBAL] = 1'b0;
      end
      if (push) begin
        st_next.sp = st_reg.sp + SP_ONE;
      end
    end else if (irq_return) begin
      if (priority_levels_enable && st_reg.ctrl_main[MAIN_GLOBAL]) begin
        st_next.ctrl_main[MAIN_PERIPH] = 1'b1;
      end else begin
        st_next.ctrl_main[MAIN_GLOBAL] = 1'b1;
      end
      if (pop) begin
        st_next.sp = pop_addr;
      end
    end

    // hardware set wins over a software clear in the same cycle
    st_next.ctrl_main[MAIN_X0_FLAG]  = st_next.ctrl_main[MAIN_X0_FLAG] | ext_edge[0];
    st_next.ctrl_third[THR_X1_FLAG] = st_next.ctrl_third[THR_X1_FLAG] | ext_edge[1];
    st_next.ctrl_third[THR_X2_FLAG] = st_next.ctrl_third[THR_X2_FLAG] | ext_edge[2];
    st_next.ctrl_main[MAIN_T0_FLAG]  = st_next.ctrl_main[MAIN_T0_FLAG] | t0_ovf;
    st_next.ctrl_main[MAIN_PC_FLAG]  = st_next.ctrl_main[MAIN_PC_FLAG] | pb_change;

    st_next.rdata = '0;
    if (rd_en) begin
      case (addr)
        OFS_CTRL_MAIN:   st_next.rdata = st_reg.ctrl_main;
        OFS_CTRL_SECOND: st_next.rdata = st_reg.ctrl_second;
        OFS_CTRL_THIRD:  st_next.rdata = st_reg.ctrl_third;
        OFS_RESET_CAUSE: st_next.rdata = st_reg.reset_cause;
        OFS_TIMER_LOW:   st_next.rdata = st_reg.timer[7:0];
        OFS_TIMER_HIGH:  st_next.rdata = st_reg.timer[15:8];
        OFS_TIMER_CFG:   st_next.rdata = st_reg.timer_cfg;
        OFS_STACK_STAT:  st_next.rdata = DATA_W'(st_reg.sp);
        default:         st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg             <= '0;
      st_reg.ctrl_main   <= MAIN_RST;
      st_reg.ctrl_second <= SECOND_RST;
      st_reg.ctrl_third  <= THIRD_RST;
      st_reg.reset_cause <= RC_RST;
      st_reg.timer_cfg   <= CFG_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata                = st_reg.rdata;
  assign return_pc            = stack_rd;
  assign return_pc_valid      = st_reg.ret_valid;
  assign working_register_out = st_reg.shadow_w;
  assign status_out           = st_reg.shadow_s;
  assign bank_select_out      = st_reg.shadow_b;
  assign restore_valid        = st_reg.fast_valid;

  a_edge_sets_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg.ext_sync[1] && !st_reg.ext_prev[1]
     && st_reg.ctrl_second[SEC_EDGE1]) |=> st_reg.ctrl_third[THR_X1_FLAG])
    else $error("rising edge did not set flag");

  a_flag_stays_set: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg.ctrl_main[MAIN_X0_FLAG] && !(wr_en && addr == OFS_CTRL_MAIN))
    |=> st_reg.ctrl_main[MAIN_X0_FLAG][*2] or (wr_en && addr == OFS_CTRL_MAIN))
    else $error("external flag dropped without a write");

  a_masked_no_req: assert property (@(posedge ref_clk) disable iff (rst)
    (!priority_levels_enable && !act_x1 && !act_x2 && !act_t0 && !act_pc && !periph_req
     && st_reg.ctrl_main[MAIN_X0_FLAG] && !st_reg.ctrl_main[MAIN_X0_EN]) |-> !irq_high_req)
    else $error("disabled source raised a request");

  a_wake_vectors: assert property (@(posedge ref_clk) disable iff (rst)
    wake_req |-> (wake_vector == st_reg.ctrl_main[MAIN_GLOBAL]))
    else $error("wake vector does not follow global enable");

  a_zero_is_high: assert property (@(posedge ref_clk) disable iff (rst)
    (priority_levels_enable && act_x0 && st_reg.ctrl_main[MAIN_GLOBAL]) |-> irq_high_req)
    else $error("source zero not high priority");

  a_wrap_eight: assert property (@(posedge ref_clk) disable iff (rst)
    (t0_ovf && st_reg.timer_cfg[CFG_EIGHT] && !wr_en)
    |=> (st_reg.timer[7:0] == 8'h00) && st_reg.ctrl_main[MAIN_T0_FLAG])
    else $error("8-bit wrap did not flag");

  a_wrap_sixteen: assert property (@(posedge ref_clk) disable iff (rst)
    (t0_ovf && !st_reg.timer_cfg[CFG_EIGHT] && !wr_en)
    |=> (st_reg.timer == 16'h0000) && st_reg.ctrl_main[MAIN_T0_FLAG])
    else $error("16-bit wrap did not flag");

  a_pin_change: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(st_reg.pb_sync) |=> st_reg.ctrl_main[MAIN_PC_FLAG])
    else $error("pin change did not set flag");

  a_ctx_saved: assert property (@(posedge ref_clk) disable iff (rst)
    push |=> (st_reg.shadow_w == $past(working_register_in))
             && (st_reg.sp == $past(st_reg.sp) + SP_ONE))
    else $error("context not saved on entry");

  a_cause_reset: assert property (@(posedge ref_clk) disable iff (rst)
    $past(rst) |-> (st_reg.reset_cause == RC_RST) && !priority_levels_enable)
    else $error("reset cause wrong after reset");

  a_unused_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_en && addr == OFS_RESET_CAUSE) |=> (rdata[6:5] == 2'b00))
    else $error("unimplemented cause bits read nonzero");
endmodule

// ---- sim/core_model.sv ----
// core side model: takes a pending request after a set latency, returns by fast return
// assumes one clock and synchronous active-high reset shared with the interrupt logic
`timescale 1ns/10ps
module core_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       take,
  input  wire logic       ret,
  input  wire logic [3:0] lat,
  input  wire logic       irq_high_req,
  input  wire logic       irq_low_req,
  output logic            irq_enter,
  output logic            irq_enter_high,
  output logic            irq_return,
  output logic            irq_return_fast
);
  logic [3:0] cnt;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_enter       <= 1'b0;
      irq_enter_high  <= 1'b0;
      irq_return      <= 1'b0;
      irq_return_fast <= 1'b0;
      cnt             <= 4'h0;
    end else begin
      irq_enter       <= 1'b0;
      irq_return      <= ret;
      // always fast return, so the handler itself saves nothing
      irq_return_fast <= ret;
      if (take && !irq_enter && (irq_high_req || irq_low_req)) begin
        cnt <= (cnt == lat) ? 4'h0 : cnt + 4'h1;
        if (cnt == lat) begin
          irq_enter      <= 1'b1;
          irq_enter_high <= irq_high_req;
        end
      end
    end
  end
endmodule

// ---- sim/test_ext_timer_pinchange_irq_logic.sv ----
// self-checking bench of the interrupt source logic
// assumes core_model.sv and the register map of irq_pkg
`timescale 1ns/10ps
module test_ext_timer_pinchange_irq_logic
  import irq_pkg::*;
;
  logic              ref_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0]        wdata = '0, rdata, d, m, s, t, r;
  logic [2:0]        ext_pin = 3'h0;
  logic [3:0]        port_b_a_hi = 4'h0, lat = 4'h0;
  logic              periph_req = '0, periph_high = '0, power_managed = '0, take = '0, ret = '0;
  logic              to_ev = 1'b0, clr_ev = 1'b0, cause_ev = 1'b0, fl;
  logic [PC_W-1:0]   pc_in = '0, pc_exp, return_pc;
  logic [7:0]        w_in = '0, s_in = '0, b_in = '0, w_out, s_out, b_out;
  logic [23:0]       ctx_exp;
  logic              irq_enter, irq_enter_high, irq_return, irq_return_fast;
  logic              irq_high_req, irq_low_req, wake_req, wake_vector;
  logic              return_pc_valid, restore_valid;
  logic [7:0]        rv [5] = '{8'h00, 8'h75, 8'hC0, 8'h1C, 8'h00};
  int                bad_count = 0, n_checks = 0, cyc = 0;

  ext_timer_pinchange_irq_logic i_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ext_pin(ext_pin),
    .port_b_a_hi(port_b_a_hi), .periph_req(periph_req), .periph_high(periph_high),
    .power_managed(power_managed), .irq_enter(irq_enter), .irq_enter_high(irq_enter_high),
    .irq_return(irq_return), .irq_return_fast(irq_return_fast), .pc_in(pc_in),
    .working_register_in(w_in), .status_in(s_in), .bank_select_in(b_in),
    .reset_instr_event(cause_ev), .wdt_timeout_event(to_ev), .wdt_clear_event(clr_ev),
    .brownout_event(cause_ev), .irq_high_req(irq_high_req), .irq_low_req(irq_low_req),
    .wake_req(wake_req), .wake_vector(wake_vector), .return_pc(return_pc),
    .return_pc_valid(return_pc_valid), .working_register_out(w_out), .status_out(s_out),
    .bank_select_out(b_out), .restore_valid(restore_valid));

  core_model i_core (.ref_clk(ref_clk), .rst(rst), .take(take), .ret(ret), .lat(lat),
    .irq_high_req(irq_high_req), .irq_low_req(irq_low_req), .irq_enter(irq_enter),
    .irq_enter_high(irq_enter_high), .irq_return(irq_return),
    .irq_return_fast(irq_return_fast));

  // expected {high, low} request from register contents and peripheral inputs
  function automatic logic [1:0] exp_req(logic [7:0] m, s, t, logic pe, pr, ph);
    logic [4:0] act;
    logic [4:0] hi;
    act = {m[5] & m[2], m[4] & m[1], m[3] & m[0], t[3] & t[0], t[4] & t[1]};
    hi  = {s[2], 1'b1, s[0], t[6], t[7]};
    if (!pe)
      return {m[7] & ((|act) | (m[6] & pr)), 1'b0};
    return {m[7] & ((|(act & hi)) | (pr & ph)), m[7] & m[6] & ((|(act & ~hi)) | (pr & ~ph))};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wr_en <= w;
    rd_en <= !w;
    addr  <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic pin_flag(input int i);
    acc(0, (i == 0) ? OFS_CTRL_MAIN : OFS_CTRL_THIRD, 8'h00);
    fl = d[(i == 0) ? MAIN_X0_FLAG : ((i == 1) ? THR_X1_FLAG : THR_X2_FLAG)];
  endtask

  task automatic tmr(input logic [7:0] cfg, input logic [7:0] hi, input logic exp);
    acc(1, OFS_TIMER_CFG, cfg & 8'h40);
    acc(1, OFS_TIMER_LOW, 8'hFE);
    acc(1, OFS_TIMER_HIGH, hi);
    acc(1, OFS_CTRL_MAIN, 8'h00);
    acc(1, OFS_TIMER_CFG, cfg);
    repeat (8) @(posedge ref_clk);
    acc(0, OFS_CTRL_MAIN, 8'h00);
    check(d[MAIN_T0_FLAG], exp);
    acc(1, OFS_TIMER_CFG, 8'h40);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial forever #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    r = 8'($urandom(79));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, last entry is an unmapped address
    for (int k = 0; k < 5; k++) begin
      acc(0, (k == 4) ? 4'h8 : k[3:0], 8'h00);
      check(d, rv[k]);
    end
    acc(1, OFS_RESET_CAUSE, 8'hFF);
    acc(0, OFS_RESET_CAUSE, 8'h00);
    check(d, 8'h9F);
    acc(1, OFS_RESET_CAUSE, 8'h00);
    acc(0, OFS_RESET_CAUSE, 8'h00);
    check(d, 8'h0C);
    acc(1, OFS_RESET_CAUSE, 8'h13);
    // instruction and brownout events clear, timeout clears, watchdog clear sets
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      {clr_ev, to_ev, cause_ev} <= 3'b001 << k;
      @(posedge ref_clk);
      {clr_ev, to_ev, cause_ev} <= 3'b000;
      acc(0, OFS_RESET_CAUSE, 8'h00);
      check(d, (k == 1) ? 8'h06 : 8'h0E);
    end
    // edge polarity: wrong edge after clear, right edge, wrong edge again
    for (int p = 0; p < 2; p++) begin
      acc(1, OFS_CTRL_SECOND, p ? 8'h75 : 8'h05);
      for (int i = 0; i < 3; i++) begin
        for (int k = 0; k < 3; k++) begin
          if (k == 0) begin
            acc(1, OFS_CTRL_MAIN, 8'h00);
            acc(1, OFS_CTRL_THIRD, 8'hC0);
          end
          @(posedge ref_clk);
          ext_pin[i] <= (k == 1) ? p[0] : !p[0];
          repeat (5) @(posedge ref_clk);
          pin_flag(i);
          check(fl, k != 0);
        end
      end
    end
    for (int k = 0; k < 4; k++) begin
      acc(1, OFS_CTRL_MAIN, 8'h00);
      acc(0, OFS_CTRL_MAIN, 8'h00);
      check(d[MAIN_PC_FLAG], 1'b0);
      @(posedge ref_clk);
      port_b_a_hi <= port_b_a_hi ^ (4'h1 << k);
      repeat (5) @(posedge ref_clk);
      acc(0, OFS_CTRL_MAIN, 8'h00);
      check(d[MAIN_PC_FLAG], 1'b1);
    end
    for (int n = 0; n < 80; n++) begin
      m = 8'($urandom);
      s = 8'($urandom);
      t = 8'($urandom);
      r = 8'($urandom);
      @(posedge ref_clk);
      periph_req  <= r[2];
      periph_high <= r[3];
      acc(1, OFS_RESET_CAUSE, r);
      acc(1, OFS_CTRL_SECOND, s);
      acc(1, OFS_CTRL_THIRD, t);
      acc(1, OFS_CTRL_MAIN, m);
      d = {6'h00, exp_req(m, s & 8'h75, t & 8'hDB, r[7], r[2], r[3])};
      check(irq_high_req, d[1]);
      check(irq_low_req, d[0]);
    end
    tmr(8'hC0, 8'h00, 1'b1);
    tmr(8'h80, 8'h00, 1'b0);
    tmr(8'h80, 8'hFF, 1'b1);
    acc(1, OFS_RESET_CAUSE, 8'h00);
    acc(1, OFS_CTRL_MAIN, 8'h10);
    acc(1, OFS_CTRL_THIRD, 8'h00);
    @(posedge ref_clk);
    power_managed <= 1'b1;
    // an enable set only after entry must not wake
    acc(1, OFS_CTRL_THIRD, 8'h09);
    check({wake_req, wake_vector}, 2'b00);
    acc(1, OFS_CTRL_THIRD, 8'h00);
    acc(1, OFS_CTRL_MAIN, 8'h12);
    check({wake_req, wake_vector}, 2'b10);
    acc(1, OFS_CTRL_MAIN, 8'h92);
    check({wake_req, wake_vector}, 2'b11);
    @(posedge ref_clk);
    power_managed <= 1'b0;
    pc_in         <= PC_W'($urandom);
    w_in          <= 8'($urandom);
    s_in          <= 8'($urandom);
    b_in          <= 8'($urandom);
    lat           <= 4'($urandom);
    take          <= 1'b1;
    for (int k = 0; k < 30 && irq_enter !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    pc_exp  = pc_in;
    ctx_exp = {w_in, s_in, b_in};
    @(posedge ref_clk);
    pc_in <= ~pc_in;
    w_in  <= ~w_in;
    take  <= 1'b0;
    #1 check({w_out, s_out, b_out}, ctx_exp);
    acc(0, OFS_CTRL_MAIN, 8'h00);
    check(d, 8'h12);
    @(posedge ref_clk);
    ret <= 1'b1;
    @(posedge ref_clk);
    ret <= 1'b0;
    for (int k = 0; k < 10 && return_pc_valid !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    check({return_pc, restore_valid}, {pc_exp, 1'b1});
    acc(1, OFS_CTRL_MAIN, 8'h90);
    check(irq_high_req, 1'b0);
    final_report();
  end
endmodule
